// ==== motor_thermal_map.vh ====
`ifndef MOTOR_THERMAL_MAP_VH
`define MOTOR_THERMAL_MAP_VH
`define CLK_HZ 25000000
`define SAMPLE_US 1000
`define SAMPLE_CYC (`CLK_HZ / 1000000 * `SAMPLE_US)
`define SAMPLES_PER_S (1000000 / `SAMPLE_US)
`define A_CTRL 8'h00
`define A_RATED 8'h01
`define A_PF 8'h02
`define A_TAU 8'h03
`define A_ILIM 8'h04
`define A_KP 8'h05
`define A_KI 8'h06
`define A_STATUS 8'h08
`define A_ACC 8'h09
`define A_OVR 8'h0a
`define A_LOAD 8'h0b
`define A_MAG 8'h0c
`define A_DISP 8'h0d
`define B_MODE 0
`define B_DSEL 1
`define B_TCLR 2
`define B_TRIP 0
`define B_RESTR 1
`define RST_RATED 16'h0064
`define RST_PF 16'h0055
`define RST_TAU 16'h0059
`define RST_ILIM 16'h0672
`define RST_KP 16'h0014
`define RST_KI 16'h0028
`define GAIN_MAX 16'h00fa
`define ABS_LIM 16'h2710
`define RESTR_LIM 16'h03e8
`define ACC_FULL 16'h03e8
`define ACC_RELEASE 16'h03b6
`define TRIP_NUM 64'd11025
`define ACC_SCALE 64'd10000000
`define LOAD_SCALE 64'd100000
`define PI_SHIFT 8
`endif

// ==== seq_divider.v ====
`timescale 1ns/100ps
module seq_divider #(
  parameter W = 64 // Operand width
) (
  input wire clk, // System clock
  input wire rst_n, // Asynchronous reset, active low
  input wire start, // Start pulse, operands taken here
  input wire [W-1:0] num, // Dividend
  input wire [W-1:0] den, // Divisor, zero gives all ones
  output reg [W-1:0] quo_r, // Quotient
  output reg done_r // One-cycle pulse, quotient valid
);
  reg [W-1:0] rem_r;
  reg [W-1:0] den_r;
  reg [7:0] cnt_r;
  wire [W:0] sh = {rem_r, quo_r[W-1]};
  wire ge = (sh >= {1'b0, den_r});
  wire [W:0] dif = sh - {1'b0, den_r};

  // One quotient bit per clock keeps the datapath to a single subtractor
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      quo_r <= {W{1'b0}};
      rem_r <= {W{1'b0}};
      den_r <= {W{1'b0}};
      cnt_r <= 8'h00;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        quo_r <= num;
        rem_r <= {W{1'b0}};
        den_r <= den;
        cnt_r <= W[7:0];
      end else if (cnt_r != 8'h00) begin
        rem_r <= ge ? dif[W-1:0] : sh[W-1:0];
        quo_r <= {quo_r[W-2:0], ge};
        cnt_r <= cnt_r - 8'h01;
        done_r <= (cnt_r == 8'h01);
      end
    end
  end
endmodule // seq_divider

// ==== motor_thermal_overload_protection.v ====
`timescale 1ns/100ps
`include "motor_thermal_map.vh"
module motor_thermal_overload_protection #(
  parameter SAMPLE_CYC = `SAMPLE_CYC // Clock cycles per model sample
) (
  input wire clk, // 25 MHz system clock
  input wire rst_n, // Asynchronous reset, active low
  input wire [7:0] addr, // Register address
  input wire [15:0] wdata, // Register write data
  input wire wr, // Write strobe
  input wire rd, // Read strobe
  output reg [15:0] rdata_r, // Read data, cycle after rd
  input wire [15:0] i_out, // Output current magnitude, 0.1 A
  input wire signed [15:0] i_act, // Active current, 0.1 A, + motoring
  input wire signed [15:0] i_mag, // Magnetising current, 0.1 A
  input wire signed [15:0] f_ramp, // Post-ramp frequency, 0.1 Hz
  input wire [15:0] f_max, // Maximum frequency, 0.1 Hz
  input wire trip_clr, // Trip reset pulse
  output reg signed [15:0] f_out_r, // Frequency after limit correction
  output reg trip_r, // Overload trip, latched
  output reg restrict_r // Current limit restricted
);
  localparam ST_IDLE = 3'd0;
  localparam ST_THERM = 3'd1;
  localparam ST_ACC = 3'd2;
  localparam ST_LOAD = 3'd3;
  localparam ST_PI = 3'd4;

  function [15:0] mag16;
    input [15:0] v;
    begin
      mag16 = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  function [15:0] min16;
    input [15:0] a;
    input [15:0] b;
    begin
      min16 = (a < b) ? a : b;
    end
  endfunction

  // Software settings
  reg mode_r;
  reg dsel_r;
  reg [15:0] rated_r;
  reg [15:0] pf_r;
  reg [15:0] tau_r;
  reg [15:0] ilim_r;
  reg [15:0] kp_r;
  reg [15:0] ki_r;
  // Model state and readouts
  reg [31:0] samp_cnt_r;
  reg [2:0] st_r;
  reg [47:0] vc_r;
  reg [47:0] diff_r;
  reg up_r;
  reg [15:0] acc_r;
  reg signed [15:0] load_r;
  reg signed [15:0] mag_r;
  reg [15:0] disp_r;
  reg [15:0] ovr_r;
  reg [23:0] integ_r;
  reg [15:0] corr_r;
  reg motoring_r;
  reg [15:0] act_abs_r;
  reg act_neg_r;
  reg div_start_r;
  reg div_wait_r;
  reg [63:0] div_num_r;
  reg [63:0] div_den_r;
  wire [63:0] quo;
  wire div_done;

  seq_divider #(.W(64)) u_div (
    .clk(clk),
    .rst_n(rst_n),
    .start(div_start_r),
    .num(div_num_r),
    .den(div_den_r),
    .quo_r(quo),
    .done_r(div_done)
  );

  wire wr_ctrl = wr && (addr == `A_CTRL);
  wire [31:0] i2 = i_out * i_out;
  wire [47:0] target = {i2, 16'h0000};
  wire [63:0] tau_den = tau_r * `SAMPLES_PER_S;
  wire [63:0] acc_num = vc_r[47:16] * `ACC_SCALE;
  wire [63:0] thr_den = rated_r * rated_r * `TRIP_NUM;
  wire [63:0] load_num = act_abs_r * `LOAD_SCALE;
  wire [63:0] load_den = rated_r * pf_r;
  wire [47:0] step = (quo[63:48] != 16'h0000 || quo[47:0] > diff_r) ? diff_r : quo[47:0];
  wire [15:0] acc_q = (quo > {48'h0, `ACC_FULL}) ? `ACC_FULL : quo[15:0];
  wire [15:0] load_q = (quo > 64'd32767) ? 16'h7fff : quo[15:0];
  wire [15:0] lim_set = min16(ilim_r, `ABS_LIM);
  wire [15:0] ovr_nxt = restrict_r ? min16(lim_set, `RESTR_LIM) : lim_set;
  wire signed [17:0] excess = {2'b00, mag16(load_r)} - {2'b00, ovr_r};
  wire [17:0] exc_abs = excess[17] ? (~excess + 18'd1) : excess;
  wire [41:0] ki_term = ki_r[7:0] * exc_abs;
  wire [41:0] kp_term = excess[17] ? 42'd0 : kp_r[7:0] * exc_abs;
  reg [23:0] integ_nxt;
  reg [41:0] corr_sum;
  reg signed [17:0] f_nxt;

  // Integrator winds up only while over the limit, bleeds back when under
  always @* begin
    if (!excess[17]) begin
      integ_nxt = ({18'd0, integ_r} + ki_term > 42'hffffff) ? 24'hffffff
                  : integ_r + ki_term[23:0];
    end else begin
      integ_nxt = ({18'd0, integ_r} < ki_term) ? 24'h000000 : integ_r - ki_term[23:0];
    end
    corr_sum = (kp_term + {18'd0, integ_nxt}) >> `PI_SHIFT;
  end

  // Correction rides on the live ramp so the ramp never stops acting
  always @* begin
    f_nxt = {f_ramp[15], f_ramp[15], f_ramp};
    if (corr_r != 16'h0000) begin
      if (motoring_r) begin
        if (!f_ramp[15]) begin
          f_nxt = f_nxt - {2'b00, corr_r};
          if (f_nxt[17]) begin
            f_nxt = 18'sd0;
          end
        end else begin
          f_nxt = f_nxt + {2'b00, corr_r};
          if (!f_nxt[17]) begin
            f_nxt = 18'sd0;
          end
        end
      end else begin
        if (!f_ramp[15]) begin
          f_nxt = f_nxt + {2'b00, corr_r};
          if (f_nxt > {2'b00, f_max}) begin
            f_nxt = {2'b00, f_max};
          end
        end else begin
          f_nxt = f_nxt - {2'b00, corr_r};
          if (f_nxt < -{2'b00, f_max}) begin
            f_nxt = -{2'b00, f_max};
          end
        end
      end
    end
  end

  // Settings port
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= 1'b0;
      dsel_r <= 1'b0;
      rated_r <= `RST_RATED;
      pf_r <= `RST_PF;
      tau_r <= `RST_TAU;
      ilim_r <= `RST_ILIM;
      kp_r <= `RST_KP;
      ki_r <= `RST_KI;
    end else if (wr) begin
      case (addr)
        `A_CTRL: begin
          mode_r <= wdata[`B_MODE];
          dsel_r <= wdata[`B_DSEL];
        end
        `A_RATED: rated_r <= wdata;
        `A_PF: pf_r <= wdata;
        `A_TAU: tau_r <= wdata;
        `A_ILIM: ilim_r <= wdata;
        `A_KP: kp_r <= min16(wdata, `GAIN_MAX);
        `A_KI: ki_r <= min16(wdata, `GAIN_MAX);
        default: ;
      endcase
    end
  end

  // Sample sequencer: thermal step, accumulator, load, limit loop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_cnt_r <= 32'h0;
      st_r <= ST_IDLE;
      vc_r <= 48'h0;
      diff_r <= 48'h0;
      up_r <= 1'b0;
      acc_r <= 16'h0;
      load_r <= 16'sh0;
      integ_r <= 24'h0;
      corr_r <= 16'h0;
      motoring_r <= 1'b1;
      act_abs_r <= 16'h0;
      act_neg_r <= 1'b0;
      div_start_r <= 1'b0;
      div_wait_r <= 1'b0;
      div_num_r <= 64'h0;
      div_den_r <= 64'h0;
    end else begin
      div_start_r <= 1'b0;
      samp_cnt_r <= (samp_cnt_r == SAMPLE_CYC - 1) ? 32'h0 : samp_cnt_r + 32'h1;
      case (st_r)
        ST_IDLE: begin
          if (samp_cnt_r == SAMPLE_CYC - 1) begin
            up_r <= (target >= vc_r);
            diff_r <= (target >= vc_r) ? target - vc_r : vc_r - target;
            div_num_r <= {16'h0000, (target >= vc_r) ? target - vc_r : vc_r - target};
            div_den_r <= tau_den;
            div_start_r <= 1'b1;
            st_r <= ST_THERM;
          end
        end
        ST_THERM: begin
          if (div_done) begin
            // Step never exceeds the gap, so the lag cannot overshoot
            vc_r <= up_r ? vc_r + step : vc_r - step;
            st_r <= ST_ACC;
          end
        end
        // Launch flag: equal successive operands must still start a divide
        ST_ACC: begin
          if (!div_wait_r) begin
            div_num_r <= acc_num;
            div_den_r <= thr_den;
            div_start_r <= 1'b1;
            div_wait_r <= 1'b1;
          end else if (div_done) begin
            acc_r <= acc_q;
            act_abs_r <= mag16(i_act);
            act_neg_r <= i_act[15];
            div_wait_r <= 1'b0;
            st_r <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (!div_wait_r) begin
            div_num_r <= load_num;
            div_den_r <= load_den;
            div_start_r <= 1'b1;
            div_wait_r <= 1'b1;
          end else if (div_done) begin
            load_r <= act_neg_r ? -load_q : load_q;
            motoring_r <= !act_neg_r;
            div_wait_r <= 1'b0;
            st_r <= ST_PI;
          end
        end
        ST_PI: begin
          integ_r <= integ_nxt;
          corr_r <= (corr_sum > 42'h00ffff) ? 16'hffff : corr_sum[15:0];
          st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Protection action; a new trip beats a clear in the same cycle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_r <= 1'b0;
      restrict_r <= 1'b0;
      ovr_r <= `RST_ILIM;
    end else begin
      if (!mode_r && acc_r >= `ACC_FULL) begin
        trip_r <= 1'b1;
      end else if (trip_clr || (wr_ctrl && wdata[`B_TCLR])) begin
        trip_r <= 1'b0;
      end
      if (!mode_r) begin
        restrict_r <= 1'b0;
      end else if (acc_r >= `ACC_FULL) begin
        restrict_r <= 1'b1;
      end else if (acc_r < `ACC_RELEASE) begin
        restrict_r <= 1'b0;
      end
      ovr_r <= ovr_nxt;
    end
  end

  // Readouts and outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mag_r <= 16'sh0;
      disp_r <= 16'h0;
      f_out_r <= 16'sh0;
      rdata_r <= 16'h0;
    end else begin
      mag_r <= i_mag;
      disp_r <= dsel_r ? i_out : load_r;
      f_out_r <= f_nxt[15:0];
      rdata_r <= 16'h0;
      if (rd) begin
        case (addr)
          `A_CTRL: rdata_r <= {14'h0, dsel_r, mode_r};
          `A_RATED: rdata_r <= rated_r;
          `A_PF: rdata_r <= pf_r;
          `A_TAU: rdata_r <= tau_r;
          `A_ILIM: rdata_r <= ilim_r;
          `A_KP: rdata_r <= kp_r;
          `A_KI: rdata_r <= ki_r;
          `A_STATUS: rdata_r <= {14'h0, restrict_r, trip_r};
          `A_ACC: rdata_r <= acc_r;
          `A_OVR: rdata_r <= ovr_r;
          `A_LOAD: rdata_r <= load_r;
          `A_MAG: rdata_r <= mag_r;
          `A_DISP: rdata_r <= disp_r;
          default: rdata_r <= 16'h0;
        endcase
      end
    end
  end
endmodule // motor_thermal_overload_protection

// ==== motor_thermal_checker_asserts.sv ====
`timescale 1ns/100ps
module motor_thermal_checker (
  input wire clk, // System clock
  input wire rst_n, // Reset, active low
  input wire [7:0] addr, // Register address
  input wire [15:0] wdata, // Write data
  input wire wr, // Write strobe
  input wire rd, // Read strobe
  input wire [15:0] rdata_r, // Read data
  input wire signed [15:0] f_ramp, // Ramp frequency
  input wire signed [15:0] f_out_r, // Corrected frequency
  input wire trip_clr, // Trip clear pulse
  input wire trip_r, // Latched trip
  input wire restrict_r // Limit restricted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_rdata_idle: assert property (!rd |=> rdata_r == 16'h0000)
    else $error("read data not zero outside a read");
  a_trip_hold: assert property (trip_r && !trip_clr && !wr |=> trip_r)
    else $error("trip dropped without a clear");
  // Restricted means mode 1, so a clear cannot be overridden by a new set
  a_trip_clear: assert property (trip_clr && restrict_r && !wr && !$past(wr) |=> !trip_r)
    else $error("trip clear ignored");
  a_restrict_off: assert property (wr && addr == 8'h00 && !wdata[0] |-> ##[1:2] !restrict_r)
    else $error("restriction kept in mode 0");
  a_gain_max: assert property (rd && (addr == 8'h05 || addr == 8'h06) |=> rdata_r <= 16'h00fa)
    else $error("gain above 250");
  a_acc_range: assert property (rd && addr == 8'h09 |=> rdata_r <= 16'h03e8)
    else $error("accumulator above 100.0");
  a_status_match: assert property (rd && addr == 8'h08 |=>
    rdata_r == {14'h0, $past(restrict_r), $past(trip_r)})
    else $error("status differs from flags");
  a_fout_sign: assert property ($past(f_ramp) > 0 |-> f_out_r >= 0)
    else $error("correction drove frequency past zero");
  c_trip: cover property ($rose(trip_r));
  c_restrict: cover property ($rose(restrict_r));
  c_corr: cover property (f_out_r != $past(f_ramp));
endmodule // motor_thermal_checker

bind motor_thermal_overload_protection motor_thermal_checker i_chk (.clk(clk), .rst_n(rst_n),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .f_ramp(f_ramp),
  .f_out_r(f_out_r), .trip_clr(trip_clr), .trip_r(trip_r), .restrict_r(restrict_r));

// ==== drive_plant.sv ====
`timescale 1ns/100ps
module drive_plant (
  input wire clk, // System clock
  input wire [15:0] amps_cmd, // Wanted current magnitude
  input wire signed [15:0] act_cmd, // Wanted active current
  input wire signed [15:0] ramp_cmd, // Wanted ramp output
  output reg [15:0] i_out = 16'h0000, // Current magnitude
  output reg signed [15:0] i_act = 16'sh0000, // Active current
  output reg signed [15:0] i_mag = 16'sh0000, // Magnetising current
  output reg signed [15:0] f_ramp = 16'sh0000, // Ramp output
  output reg [15:0] f_max = 16'h0000 // Maximum frequency
);
  // Moves only after an edge, so the sequencer sees steady values
  always @(posedge clk) begin
    i_out <= amps_cmd;
    i_act <= act_cmd;
    i_mag <= 16'sh002a;
    f_ramp <= ramp_cmd;
    f_max <= 16'h03e8;
  end
endmodule // drive_plant

// ==== motor_thermal_overload_protection_tb.sv ====
`timescale 1ns/100ps
module motor_thermal_overload_protection_tb;
  typedef struct {logic [7:0] a; logic [15:0] e;} row_t;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, trip_clr = 0, trip_r, restrict_r;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, amps = 16'h0000, rdata_r, i_out, f_max, d;
  logic signed [15:0] act = 16'sh0000, ramp = 16'sh01f4, i_act, i_mag, f_ramp, f_out_r;
  int fails = 0, n_tests = 0, cyc = 0;
  row_t rows [14] = '{'{8'h00, 16'h0000}, '{8'h01, 16'h0064}, '{8'h02, 16'h0055},
    '{8'h03, 16'h0059}, '{8'h04, 16'h0672}, '{8'h05, 16'h0014}, '{8'h06, 16'h0028},
    '{8'h08, 16'h0000}, '{8'h09, 16'h0000}, '{8'h0a, 16'h0672}, '{8'h0b, 16'h0000},
    '{8'h0c, 16'h002a}, '{8'h0d, 16'h0000}, '{8'h0e, 16'h0000}};
  drive_plant i_plant (.clk(clk), .amps_cmd(amps), .act_cmd(act), .ramp_cmd(ramp),
    .i_out(i_out), .i_act(i_act), .i_mag(i_mag), .f_ramp(f_ramp), .f_max(f_max));
  motor_thermal_overload_protection #(.SAMPLE_CYC(400)) i_dut (.clk(clk), .rst_n(rst_n),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata_r(rdata_r), .i_out(i_out),
    .i_act(i_act), .i_mag(i_mag), .f_ramp(f_ramp), .f_max(f_max), .trip_clr(trip_clr),
    .f_out_r(f_out_r), .trip_r(trip_r), .restrict_r(restrict_r));
  always #20 clk = ~clk;
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      report_and_stop();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(n, e, rdata_r);
  endtask
  // Three sample periods: the second sample starts and ends on steady inputs
  task automatic plant(input logic [15:0] a, input logic signed [15:0] c);
    @(posedge clk);
    amps <= a;
    act <= c;
    repeat (1200) @(posedge clk);
    #1;
  endtask
  task automatic pulse_clr;
    @(posedge clk);
    trip_clr <= 1'b1;
    @(posedge clk);
    trip_clr <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    plant(16'h0000, 16'sh0000);
    foreach (rows[i]) rchk("reset_reg", rows[i].a, rows[i].e);
    $display("test reset values done");
    wreg(8'h05, 16'h012c);
    rchk("kp_sat", 8'h05, 16'h00fa);
    plant(16'h0025, 16'sh0055);
    rchk("load", 8'h0b, 16'h03e8);
    chk("f_free", 16'h01f4, f_out_r);
    plant(16'h0025, -16'sh0055);
    rchk("load_neg", 8'h0b, 16'hfc18);
    wreg(8'h00, 16'h0002);
    rchk("disp_amps", 8'h0d, 16'h0025);
    wreg(8'h00, 16'h0000);
    wreg(8'h04, 16'h4e20);
    repeat (3) @(posedge clk);
    rchk("ovr_cap", 8'h0a, 16'h2710);
    wreg(8'h04, 16'h0672);
    $display("test registers and load done");
    wreg(8'h03, 16'h0000);
    plant(16'h0068, 16'sh0000);
    rchk("acc_104", 8'h09, 16'h03d5);
    chk("no_trip", 16'h0000, {15'h0, trip_r});
    plant(16'h0069, 16'sh0000);
    rchk("acc_105", 8'h09, 16'h03e8);
    chk("trip", 16'h0001, {15'h0, trip_r});
    plant(16'h0000, 16'sh0000);
    chk("trip_held", 16'h0001, {15'h0, trip_r});
    pulse_clr();
    chk("trip_cleared", 16'h0000, {15'h0, trip_r});
    wreg(8'h00, 16'h0001);
    plant(16'h0069, 16'sh0000);
    chk("restrict", 16'h0001, {15'h0, restrict_r});
    chk("mode1_no_trip", 16'h0000, {15'h0, trip_r});
    rchk("ovr_restr", 8'h0a, 16'h03e8);
    pulse_clr();
    plant(16'h0068, 16'sh0000);
    chk("restr_hyst", 16'h0001, {15'h0, restrict_r});
    plant(16'h0064, 16'sh0000);
    chk("restr_off", 16'h0000, {15'h0, restrict_r});
    $display("test thermal done");
    plant(16'h0064, 16'sh0bb8);
    chk("f_motor", 16'h0000, f_out_r);
    plant(16'h0064, -16'sh0bb8);
    chk("f_regen", 16'h03e8, f_out_r);
    $display("test limit loop done");
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    chk("restr_rst", 16'h0000, {15'h0, restrict_r});
    rchk("acc_rst", 8'h09, 16'h0000);
    rchk("kp_rst", 8'h05, 16'h0014);
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule // motor_thermal_overload_protection_tb
